/* hdl/smp_pkg.sv */
package smp_pkg;
  // lane packing codes
  localparam logic [1:0] PACK_TWO = 2'h0;
  localparam logic [1:0] PACK_FOUR = 2'h1;
  localparam logic [1:0] PACK_EIGHT = 2'h2;
  // resolution codes
  localparam logic [1:0] RES_12 = 2'h0;
  localparam logic [1:0] RES_14 = 2'h1;
  localparam logic [1:0] RES_16 = 2'h2;
  // minimum multiframe octets
  localparam int MIN_MF_OCTETS = 17;
  // register offsets
  localparam logic [3:0] ADDR_CFG = 4'h0;
  localparam logic [3:0] ADDR_BOOST = 4'h1;
  localparam logic [3:0] ADDR_INIT = 4'h2;
  localparam logic [3:0] ADDR_LINK = 4'h3;
  localparam logic [3:0] ADDR_COUNT = 4'h4;
  // reset values
  localparam logic [1:0] RST_PACK = PACK_FOUR;
  localparam logic [1:0] RST_RES = RES_12;
  localparam logic [3:0] RST_BOOST = 4'h0;
  localparam logic [4:0] RST_INIT = 5'h00;
  // cfg field positions
  localparam int CFG_RES_LSB = 0;
  localparam int CFG_PACK_LSB = 2;
  localparam int CFG_FORCE_BIT = 4;

  typedef struct packed {
    logic [4:0] frame_octets;
    logic [2:0] mf_frames;
    logic [5:0] mf_octets;
    logic [4:0] k_field;
  } smp_link_t;

  typedef struct packed {
    logic [1:0] pack;
    logic [1:0] res;
    logic force_en;
  } smp_cfg_t;
endpackage

/* hdl/smp_geometry.sv */
`timescale 1ns/1ps
module smp_geometry (
  input wire logic [1:0] pack,  // converters per lane code
  input wire logic [1:0] res,  // resolution code
  output smp_pkg::smp_link_t link  // derived link geometry
);
  // frame and multiframe sizes per packing and resolution
  always_comb begin
    link = '0;
    unique case (pack)
      smp_pkg::PACK_TWO: link.frame_octets = (res == smp_pkg::RES_12) ? 5'h03 : 5'h04;
      smp_pkg::PACK_EIGHT: begin
        link.frame_octets = (res == smp_pkg::RES_12) ? 5'h0c :
                            (res == smp_pkg::RES_14) ? 5'h0e : 5'h10;
      end
      default: begin
        link.frame_octets = (res == smp_pkg::RES_12) ? 5'h06 :
                            (res == smp_pkg::RES_14) ? 5'h07 : 5'h08;
      end
    endcase
    // table meets ceil of seventeen over frame octets
    unique case (pack)
      smp_pkg::PACK_TWO: link.mf_frames = (res == smp_pkg::RES_12) ? 3'h6 : 3'h5;
      smp_pkg::PACK_EIGHT: link.mf_frames = 3'h2;
      default: link.mf_frames = 3'h3;
    endcase
    link.mf_octets = {1'b0, link.frame_octets} * {3'h0, link.mf_frames};
    link.k_field = 5'(link.mf_frames - 3'h1);
  end
endmodule

/* hdl/smp_framer.sv */
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// Behaviour
// - multiframe frames at least ceil(17 / octets per frame).
// - multiframe length sets local multiframe clock period, one cycle each.
// - frame octets from resolution and converters per lane.
// - multiframe frames from resolution and converters per lane.
// - converters per lane come from a lane-packing control.
// - five-bit k field carries multiframe frames minus one.
// - reset gives four per lane, 12 bit, multiframe three frames.
// - boost drive current only on bits differing from previous bit.
// - boost chosen from 16 settings of 0.25 mA steps.
// - sync events reload counter with zero or forced init value.
module smp_framer (
  input wire logic clk,  // device clock
  input wire logic rst,  // async reset, high
  input wire logic ce,  // clock enable
  input wire logic [3:0] addr,  // register address
  input wire logic [7:0] wdata,  // write data
  input wire logic wr,  // write strobe
  input wire logic rd,  // read strobe
  output logic [7:0] rdata,  // read data
  input wire logic sync_n_pin,  // sync from receiver, low active
  input wire logic sysref_pin,  // sysref pin
  input wire logic tx_bit,  // next serial bit
  input wire logic octet_strobe,  // one pulse per octet
  output logic serial_lane_out,  // serial bit out
  output logic [3:0] drive_boost,  // boost steps on this bit
  output logic boost_active,  // bit differs from previous bit
  output logic lmfc,  // local multiframe clock
  output logic mf_last_octet,  // last octet of multiframe
  output logic [4:0] k_field  // link config k field
);
  // state groups, each frozen while ce is low so a paused link resumes
  // exactly where it stopped:
  // - register file: configuration, boost setting, counter init, read data
  // - pin synchronisers and edge history for the two sync sources
  // - multiframe position: octet in multiframe, frame index, octet in frame
  // - serial path: delayed bit, previous bit and boost decision
  // all outputs come from flops; the geometry is combinational but feeds
  // next-state logic only, never a port directly
  // register file state
  smp_pkg::smp_cfg_t cfg_q, cfg_d;
  logic [3:0] transition_boost_setting_q, transition_boost_setting_d;
  logic [4:0] multiframe_count_init_q, multiframe_count_init_d;
  logic [7:0] rdata_q, rdata_d;
  // synchroniser and edge history state
  logic [1:0] sync_sr_q, sync_sr_d;
  logic [1:0] sref_sr_q, sref_sr_d;
  logic sync_old_q, sync_old_d;
  logic sref_old_q, sref_old_d;
  // multiframe position
  logic [5:0] oct_q, oct_d;
  logic [4:0] frm_q, frm_d;
  logic [4:0] oct_in_frm_q, oct_in_frm_d;
  // multiframe clock and last-octet pulse
  logic lmfc_q, lmfc_d;
  logic last_q, last_d;
  // serial path
  logic prev_q, prev_d;
  logic ser_q, ser_d;
  logic [3:0] boost_q, boost_d;
  logic bact_q, bact_d;
  // link field
  logic [4:0] k_q, k_d;
  // event and geometry
  logic sync_evt;
  smp_pkg::smp_link_t link;
  logic force_multiframe_count_en;

  // forcing of the reload value comes straight from the config bit
  assign force_multiframe_count_en = cfg_q.force_en;

  // geometry from packing and resolution, recomputed every cycle
  // lane packing selects geometry
  smp_geometry u_geo (
    .pack(cfg_q.pack),
    .res(cfg_q.res),
    .link(link)
  );

  // register file next state
  // writes land on the edge that sees wr; a read answers in the next cycle
  // and the word drops back to zero after one cycle, so a master that
  // samples late sees zero rather than stale data
  // unmapped writes are dropped, unmapped reads return zero, and the link
  // and count registers are read only
  always_comb begin
    cfg_d = cfg_q;
    transition_boost_setting_d = transition_boost_setting_q;
    multiframe_count_init_d = multiframe_count_init_q;
    rdata_d = 8'h00;
    // writes
    if (wr) begin
      unique case (addr)
        smp_pkg::ADDR_CFG: begin
          cfg_d.res = wdata[smp_pkg::CFG_RES_LSB +: 2];
          cfg_d.pack = wdata[smp_pkg::CFG_PACK_LSB +: 2];
          cfg_d.force_en = wdata[smp_pkg::CFG_FORCE_BIT];
        end
        smp_pkg::ADDR_BOOST: begin
          transition_boost_setting_d = wdata[3:0];
        end
        smp_pkg::ADDR_INIT: begin
          multiframe_count_init_d = wdata[4:0];
        end
        default: ;
      endcase
    end
    // read data for the next cycle
    if (rd) begin
      unique case (addr)
        smp_pkg::ADDR_CFG: begin
          rdata_d = {3'h0, cfg_q.force_en, cfg_q.pack, cfg_q.res};
        end
        smp_pkg::ADDR_BOOST: begin
          rdata_d = {4'h0, transition_boost_setting_q};
        end
        smp_pkg::ADDR_INIT: begin
          rdata_d = {3'h0, multiframe_count_init_q};
        end
        smp_pkg::ADDR_LINK: begin
          rdata_d = {3'h0, k_q};
        end
        smp_pkg::ADDR_COUNT: begin
          rdata_d = {3'h0, frm_q};
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  // register flops; reset gives the default link of four converters per
  // lane at 12 bit with a three-frame multiframe and no boost
  // reset defaults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q <= '{pack: smp_pkg::RST_PACK, res: smp_pkg::RST_RES, force_en: 1'b0};
      transition_boost_setting_q <= smp_pkg::RST_BOOST;
      multiframe_count_init_q <= smp_pkg::RST_INIT;
      rdata_q <= 8'h00;
    end else if (ce) begin
      cfg_q <= cfg_d;
      transition_boost_setting_q <= transition_boost_setting_d;
      multiframe_count_init_q <= multiframe_count_init_d;
      rdata_q <= rdata_d;
    end
  end

  // read data straight from its flop
  assign rdata = rdata_q;

  // sync and sysref arrive from outside the clock domain, so each passes
  // two flops before anything reads it; the edge history flop then reads
  // only the second stage, never the first
  // the history flops reset to the idle level of their pin, so releasing
  // reset never fakes an edge: sync idles high, sysref idles low
  // pin synchronisers and event detect
  always_comb begin
    sync_sr_d = {sync_sr_q[0], sync_n_pin};
    sref_sr_d = {sref_sr_q[0], sysref_pin};
    sync_old_d = sync_sr_q[1];
    sref_old_d = sref_sr_q[1];
  end
  // a rising sync ends a resync request from the receiver;
  // a rising sysref is the periodic or one-shot alignment strobe
  // sync rising edge or sysref rising edge
  assign sync_evt = (sync_sr_q[1] & ~sync_old_q) | (sref_sr_q[1] & ~sref_old_q);

  // synchroniser and history flops, reset to the idle level of each pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_sr_q <= 2'h3;
      sref_sr_q <= 2'h0;
      sync_old_q <= 1'b1;
      sref_old_q <= 1'b0;
    end else if (ce) begin
      sync_sr_q <= sync_sr_d;
      sref_sr_q <= sref_sr_d;
      sync_old_q <= sync_old_d;
      sref_old_q <= sref_old_d;
    end
  end

  // multiframe counter, counts frames and octets
  // position is kept three ways: octet index in the multiframe, frame
  // index and octet index in the frame; the octet index alone finds the
  // last octet, the frame index serves the count readback
  // a sync event wins over an octet strobe in the same cycle, because the
  // event defines where the multiframe starts
  // a forced init value beyond the last frame index would park the counter
  // outside the multiframe, so it falls back to zero
  // the geometry may change mid-multiframe; the octet index then runs on
  // until it wraps, so software should resync after a change
  always_comb begin
    // default: hold position, no last pulse, follow the geometry
    oct_d = oct_q;
    frm_d = frm_q;
    oct_in_frm_d = oct_in_frm_q;
    lmfc_d = lmfc_q;
    last_d = 1'b0;
    k_d = link.k_field;
    if (sync_evt) begin
      if (force_multiframe_count_en) begin
        frm_d = multiframe_count_init_q;
      end else begin
        frm_d = 5'h00;
      end
      if (frm_d > link.k_field) begin
        frm_d = 5'h00;
      end
      oct_in_frm_d = 5'h00;
      oct_d = 6'(frm_d * link.frame_octets);
      lmfc_d = 1'b1;
    end else if (octet_strobe) begin
      if (oct_q == 6'(link.mf_octets - 6'h01)) begin
        // wrap to the start of the next multiframe
        last_d = 1'b1;
        oct_d = 6'h00;
        frm_d = 5'h00;
        oct_in_frm_d = 5'h00;
      end else begin
        // step the octet and, at the end of a frame, the frame
        oct_d = 6'(oct_q + 6'h01);
        if (oct_in_frm_q == 5'(link.frame_octets - 5'h01)) begin
          oct_in_frm_d = 5'h00;
          frm_d = 5'(frm_q + 5'h01);
        end else begin
          oct_in_frm_d = 5'(oct_in_frm_q + 5'h01);
        end
      end
      // one clock cycle per multiframe, high in first half
      // the high half is rounded down for an odd octet count
      lmfc_d = (oct_d < {1'b0, link.mf_octets[5:1]});
    end
  end

  // multiframe position flops; the link field resets to three frames
  // minus one to match the reset geometry
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oct_q <= 6'h00;
      frm_q <= 5'h00;
      oct_in_frm_q <= 5'h00;
      lmfc_q <= 1'b1;
      last_q <= 1'b0;
      k_q <= 5'h02;
    end else if (ce) begin
      oct_q <= oct_d;
      frm_q <= frm_d;
      oct_in_frm_q <= oct_in_frm_d;
      lmfc_q <= lmfc_d;
      last_q <= last_d;
      k_q <= k_d;
    end
  end

  // outputs straight from flops
  assign lmfc = lmfc_q;
  assign mf_last_octet = last_q;
  // the link field lags a config write by one clock
  // k field output
  assign k_field = k_q;

  // the serial path delays each bit by one clock and decides the boost for
  // that same bit, so boost and bit leave the block aligned
  // the previous bit is the one last sent, so a pause with ce low does not
  // turn the next bit into a false transition
  // boost steps are 0.25 mA each above the base drive; zero turns boost off
  // serial output with transition boost
  always_comb begin
    ser_d = tx_bit;
    prev_d = tx_bit;
    bact_d = (tx_bit != prev_q);
    // the boost value stays zero whenever the bit repeats
    boost_d = bact_d ? transition_boost_setting_q : 4'h0;
  end

  // serial path flops; the line idles low out of reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ser_q <= 1'b0;
      prev_q <= 1'b0;
      bact_q <= 1'b0;
      boost_q <= 4'h0;
    end else if (ce) begin
      ser_q <= ser_d;
      prev_q <= prev_d;
      bact_q <= bact_d;
      boost_q <= boost_d;
    end
  end

  // driver controls
  assign serial_lane_out = ser_q;
  assign drive_boost = boost_q;
  assign boost_active = bact_q;
endmodule

/* tb/smp_framer_props.sv */
`timescale 1ns/1ps
module smp_framer_props (
  input wire logic clk,  // clock
  input wire logic rst,  // reset
  input wire logic ce,  // enable
  input wire logic [3:0] addr,  // address
  input wire logic rd,  // read
  input wire logic [7:0] rdata,  // read data
  input wire logic tx_bit,  // bit in
  input wire logic octet_strobe,  // octet
  input wire logic serial_lane_out,  // bit out
  input wire logic [3:0] drive_boost,  // boost
  input wire logic boost_active,  // boosted
  input wire logic lmfc,  // lmfc
  input wire logic mf_last_octet,  // last octet
  input wire logic [4:0] k_field  // k
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // bit path and boost decisions
  property p_ser;
    $past(ce) && !$past(rst) |-> serial_lane_out == $past(tx_bit);
  endproperty
  property p_boost;
    $past(ce) && !$past(rst) |-> boost_active == (serial_lane_out != $past(serial_lane_out));
  endproperty
  property p_noboost;
    !boost_active |-> drive_boost == 4'h0;
  endproperty
  property p_klegal;
    k_field inside {5'h05, 5'h04, 5'h02, 5'h01};
  endproperty
  property p_rst;
    $past(rst) |-> k_field == 5'h02 && lmfc && !mf_last_octet;
  endproperty
  property p_last;
    mf_last_octet |-> $past(octet_strobe) && $past(ce);
  endproperty
  property p_rdidle;
    !$past(rd && ce) |-> rdata == 8'h00;
  endproperty
  property p_rdlink;
    $past(rd && ce && addr == 4'h3) |-> rdata == {3'h0, $past(k_field)};
  endproperty
  a_ser: assert property (p_ser) else $error("serial bit not delayed tx bit");
  a_boost: assert property (p_boost) else $error("boost flag wrong");
  a_noboost: assert property (p_noboost) else $error("boost without transition");
  a_klegal: assert property (p_klegal) else $error("k field illegal");
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_last: assert property (p_last) else $error("last octet without strobe");
  a_rdidle: assert property (p_rdidle) else $error("read data not idle");
  a_rdlink: assert property (p_rdlink) else $error("link read not k");
  c_boost: cover property (boost_active);
  c_last: cover property (mf_last_octet);
  c_keight: cover property (k_field == 5'h01);
endmodule
bind smp_framer smp_framer_props i_smp_framer_props (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
  .rd(rd), .rdata(rdata), .tx_bit(tx_bit), .octet_strobe(octet_strobe),
  .serial_lane_out(serial_lane_out), .drive_boost(drive_boost), .boost_active(boost_active),
  .lmfc(lmfc), .mf_last_octet(mf_last_octet), .k_field(k_field));

/* tb/smp_rx_model.sv */
`timescale 1ns/1ps
// receiver: holds sync low a few cycles, then lets go
module smp_rx_model (
  input wire logic clk,  // device clock
  input wire logic resync,  // ask for a resync
  output logic sync_n  // sync request, low active
);
  logic [2:0] cnt_q = 3'h0;
  // count down the low time
  always @(posedge clk) begin
    if (resync) begin
      cnt_q <= 3'h4;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end
  assign sync_n = (cnt_q == 3'h0);
endmodule

/* tb/smp_framer_bench.sv */
`timescale 1ns/1ps
module smp_framer_bench;
  logic clk, rst, ce, wr, rd, sysref_pin, tx_bit, octet_strobe, resync, sync_n;
  logic ser, act, lmfc, last;
  logic [3:0] addr;
  logic [3:0] boost;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [4:0] k;
  int num_errors = 0;
  int n_tests = 0;
  smp_framer i_smp_framer (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .sync_n_pin(sync_n), .sysref_pin(sysref_pin), .tx_bit(tx_bit),
    .octet_strobe(octet_strobe), .serial_lane_out(ser), .drive_boost(boost),
    .boost_active(act), .lmfc(lmfc), .mf_last_octet(last), .k_field(k));
  smp_rx_model i_smp_rx_model (.clk(clk), .resync(resync), .sync_n(sync_n));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic final_report;
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // bounded wait for the last-octet pulse
  task automatic wait_last;
    for (int i = 0; last !== 1'b1; i++) begin
      @(posedge clk);
      #1;
      if (i > 200) begin
        num_errors++;
        final_report;
      end
    end
  endtask
  // all packings and resolutions, octets streaming every cycle
  task automatic geo_sweep;
    int oct[9] = '{3, 4, 4, 6, 7, 8, 12, 14, 16};
    int frm[9] = '{6, 5, 5, 3, 3, 3, 2, 2, 2};
    int n, j, rises;
    logic pl;
    for (int p = 0; p < 3; p++) begin
      for (int r = 0; r < 3; r++) begin
        j = p * 3 + r;
        wr_reg(4'h0, 8'(p * 4 + r));
        @(posedge clk);
        #1;
        chk(8'(k), 8'(frm[j] - 1));
        wait_last;
        rises = 0;
        pl = lmfc;
        for (n = 1; n < 40; n++) begin
          @(posedge clk);
          #1;
          if (lmfc && !pl) rises++;
          pl = lmfc;
          if (last === 1'b1) break;
        end
        chk(8'(n), 8'(oct[j] * frm[j]));
        chk(8'(n >= 17), 8'h01);
        chk(8'(rises), 8'h01);
      end
    end
  endtask
  // counter reload on events, default and forced
  task automatic sync_reload;
    wr_reg(4'h0, 8'h04);
    wait_last;
    repeat (7) @(posedge clk);
    octet_strobe <= 1'b0;
    rd_reg(4'h4, 8'h01);
    sysref_pin <= 1'b1;
    @(posedge clk);
    sysref_pin <= 1'b0;
    repeat (5) @(posedge clk);
    rd_reg(4'h4, 8'h00);
    wr_reg(4'h2, 8'h02);
    wr_reg(4'h0, 8'h14);
    resync <= 1'b1;
    @(posedge clk);
    resync <= 1'b0;
    repeat (10) @(posedge clk);
    rd_reg(4'h4, 8'h02);
  endtask
  // boost on changed bits only, gated writes ignored
  task automatic boost_run;
    logic [7:0] pat = 8'h69;
    logic pv = 1'b0;
    wr_reg(4'h1, 8'h0f);
    ce <= 1'b0;
    wr_reg(4'h1, 8'h03);
    ce <= 1'b1;
    rd_reg(4'h1, 8'h0f);
    for (int i = 0; i <= 8; i++) begin
      @(posedge clk);
      if (i < 8) tx_bit <= pat[i];
      #1;
      if (i > 0) begin
        chk(8'(boost), (pat[i - 1] != pv) ? 8'h0f : 8'h00);
        chk(8'(act), 8'(pat[i - 1] != pv));
        chk(8'(ser), 8'(pat[i - 1]));
        pv = pat[i - 1];
      end
    end
  endtask
  initial begin
    {rst, ce} = 2'h3;
    {wr, rd, sysref_pin, tx_bit, octet_strobe, resync} = 6'h00;
    addr = 4'h0;
    wdata = 8'h00;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(8'(k), 8'h02);
    rd_reg(4'h0, 8'h04);
    rd_reg(4'hf, 8'h00);
    rd_reg(4'h3, 8'h02);
    octet_strobe <= 1'b1;
    geo_sweep;
    sync_reload;
    boost_run;
    final_report;
  end
endmodule
